// ---- rtl/cpr_pkg.sv ----
// constants, encodings and state types of the cpu register core
`default_nettype none
package cpr_pkg;
  localparam int unsigned GR_COUNT = 8;
  localparam logic [3:0] ADDR_PC = 4'h8;
  localparam logic [3:0] ADDR_SR = 4'h9;
  localparam logic [3:0] ADDR_CP = 4'ha;
  localparam logic [3:0] ADDR_DP = 4'hb;
  localparam logic [3:0] ADDR_EP = 4'hc;
  localparam logic [3:0] ADDR_TP = 4'hd;
  localparam logic [3:0] ADDR_BR = 4'he;
  localparam logic [2:0] SP_INDEX = 3'h7;
  localparam logic [15:0] STACK_STEP = 16'h0002;
  localparam int unsigned SR_TRACE_BIT = 15;
  localparam int unsigned SR_MASK_MSB = 10;
  localparam int unsigned SR_MASK_LSB = 8;
  localparam logic SR_TRACE_RESET = 1'b0;
  localparam logic [2:0] SR_MASK_RESET = 3'h7;
  localparam logic [15:0] SR_WRITE_MASK = 16'h870f;
  localparam logic [15:0] PC_RESET_VAL = 16'h0000;
  localparam logic [7:0] PREFIX_CODE = 8'h00;
  localparam logic [1:0] LANE_NONE = 2'b00;
  localparam logic [1:0] LANE_LOW = 2'b01;
  localparam logic [1:0] LANE_HIGH = 2'b10;
  localparam logic [1:0] LANE_BOTH = 2'b11;

  typedef enum logic [2:0] {
    OP_NONE = 3'h0, OP_BYTE = 3'h1, OP_WORD = 3'h2, OP_LONG = 3'h3,
    OP_BCD = 3'h4, OP_BSET = 3'h5, OP_BCLR = 3'h6, OP_BNOT = 3'h7
  } cpr_op_t;
  typedef enum logic [1:0] {
    STK_NONE = 2'h0, STK_PREDEC = 2'h1, STK_POSTINC = 2'h2
  } cpr_stack_t;
  typedef enum logic [1:0] {
    FMT_GENERAL = 2'h0, FMT_PREFIXED = 2'h1, FMT_SPECIAL = 2'h2
  } cpr_fmt_t;
  typedef enum logic [1:0] {
    ST_VEC = 2'b01, ST_RUN = 2'b10
  } cpr_state_t;
  typedef enum logic [4:0] {
    D_FIRST = 5'b00001, D_EXT = 5'b00010, D_OP = 5'b00100,
    D_PREOP = 5'b01000, D_TAIL = 5'b10000
  } cpr_dec_t;
endpackage
`default_nettype wire

// ---- rtl/cpr_mem_if.sv ----
// memory request carrier between the core and its alignment checker
`default_nettype none
interface cpr_mem_if;
  logic req;
  logic [15:0] addr;
  logic word;
  logic [1:0] laneEn;
  logic err;
  modport core (output req, output addr, output word, input laneEn, input err);
  modport chk (input req, input addr, input word, output laneEn, output err);
endinterface
`default_nettype wire

// ---- rtl/cpr_align_check.sv ----
// word alignment check and byte lane selection for memory accesses
`default_nettype none
module cpr_align_check import cpr_pkg::*; (
  cpr_mem_if.chk mem
);
  always_comb begin
    mem.err = mem.req && mem.word && mem.addr[0];
    if (!mem.req || mem.err) begin
      mem.laneEn = LANE_NONE;
    end else if (mem.word) begin
      mem.laneEn = LANE_BOTH;
    end else if (mem.addr[0]) begin
      mem.laneEn = LANE_LOW;
    end else begin
      mem.laneEn = LANE_HIGH;
    end
  end
endmodule // cpr_align_check
`default_nettype wire

// ---- rtl/cpr_insn_format.sv ----
// instruction byte stream classifier: general, prefixed and special formats
`default_nettype none
module cpr_insn_format import cpr_pkg::*; (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic byteValid,
  input wire logic [7:0] byteIn,
  input wire logic [1:0] tailLen,
  output logic fmtValid,
  output cpr_fmt_t fmtKind,
  output logic [7:0] eaField,
  output logic [7:0] opcode,
  output logic [15:0] eaExt
);
  cpr_dec_t state_q;
  logic [1:0] left_q;
  logic [2:0] info;

  // {is ea field, extension length}
  function automatic logic [2:0] eaInfo(input logic [7:0] b);
    logic [2:0] r;
    r = 3'h0;
    if (b[7:4] == 4'ha || b[7:4] == 4'hd || b[7:4] == 4'hb || b[7:4] == 4'hc) begin
      r = 3'h4;
    end else if (b[7:4] == 4'he || b == 8'h04) begin
      r = 3'h5;
    end else if (b[7:4] == 4'hf || b == 8'h0c) begin
      r = 3'h6;
    end else if (b[7:4] == 4'h0 && b[2:0] == 3'h5) begin
      r = 3'h5;
    end else if (b[7:4] == 4'h1 && b[2:0] == 3'h5) begin
      r = 3'h6;
    end
    return r;
  endfunction

  assign info = eaInfo(byteIn);

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      state_q <= D_FIRST;
      left_q <= 2'h0;
      fmtValid <= 1'b0;
      fmtKind <= FMT_GENERAL;
      eaField <= 8'h00;
      opcode <= 8'h00;
      eaExt <= 16'h0000;
    end else begin
      fmtValid <= 1'b0;
      if (byteValid) begin
        case (state_q)
          D_FIRST: begin
            if (info[2]) begin
              eaField <= byteIn;
              eaExt <= 16'h0000;
              left_q <= info[1:0];
              state_q <= (info[1:0] != 2'h0) ? D_EXT : D_OP;
            end else begin
              opcode <= byteIn;
              eaField <= 8'h00;
              eaExt <= 16'h0000;
              fmtKind <= FMT_SPECIAL;
              left_q <= tailLen;
              if (tailLen == 2'h0) begin
                fmtValid <= 1'b1;
              end else begin
                state_q <= D_TAIL;
              end
            end
          end
          D_EXT: begin
            eaExt <= {eaExt[7:0], byteIn};
            left_q <= left_q - 2'h1;
            if (left_q == 2'h1) begin
              state_q <= D_OP;
            end
          end
          D_OP: begin
            if (byteIn == PREFIX_CODE) begin
              state_q <= D_PREOP;
            end else begin
              opcode <= byteIn;
              fmtKind <= FMT_GENERAL;
              fmtValid <= 1'b1;
              state_q <= D_FIRST;
            end
          end
          D_PREOP: begin
            opcode <= byteIn;
            fmtKind <= FMT_PREFIXED;
            fmtValid <= 1'b1;
            state_q <= D_FIRST;
          end
          D_TAIL: begin
            {eaField, eaExt} <= {eaExt, byteIn};
            left_q <= left_q - 2'h1;
            if (left_q == 2'h1) begin
              fmtValid <= 1'b1;
              state_q <= D_FIRST;
            end
          end
          default: begin
            state_q <= D_FIRST;
          end
        endcase
      end
    end
  end
endmodule // cpr_insn_format
`default_nettype wire

// ---- rtl/cpr_core_regs.sv ----
// cpu register file: reset state, operand formats, memory lanes, stack checks
`default_nettype none
module cpr_core_regs import cpr_pkg::*; (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic maxMode,
  output logic vecReq,
  input wire logic vecValid,
  input wire logic [15:0] vecPc,
  input wire logic [7:0] vecCodePage,
  output logic running,
  input wire logic [3:0] regAddr,
  input wire logic [15:0] regWData,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [15:0] regRData,
  input wire logic opValid,
  input wire cpr_op_t opKind,
  input wire logic [2:0] opReg,
  input wire logic [31:0] opData,
  input wire logic [3:0] opBitNum,
  input wire logic opFromMem,
  input wire logic opMemWord,
  output logic opBitValue,
  output logic [15:0] opResult,
  input wire logic memValid,
  input wire logic [15:0] memAddr,
  input wire logic memWord,
  input wire logic memWrite,
  input wire logic [15:0] memData,
  input wire cpr_stack_t memStack,
  input wire logic memExc,
  output logic busReq,
  output logic [15:0] busAddr,
  output logic busWrite,
  output logic [1:0] busLaneEn,
  output logic [15:0] busWData,
  output logic addrError,
  input wire logic insnValid,
  input wire logic [7:0] insnByte,
  input wire logic [1:0] insnTailLen,
  output logic fmtValid,
  output cpr_fmt_t fmtKind,
  output logic [7:0] fmtEaField,
  output logic [7:0] fmtOpcode,
  output logic [15:0] fmtEaExt
);
  logic [1:0] rstSync_q;
  logic rstn;
  cpr_state_t state_q;
  logic [15:0] gr_q [GR_COUNT];
  logic [15:0] pc_q;
  logic srTrace_q;
  logic [2:0] srMask_q;
  logic [3:0] srFlags_q;
  logic [7:0] codePage_q, dataPage_q, extPage_q, stackPage_q, base_q;
  logic [15:0] srView, spNow, effAddr, spNext, memOperand;
  logic opGo, memGo, spUpdate;
  logic [3:0] memBit;
  cpr_mem_if mem ();
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      rstSync_q <= 2'b00;
    end else begin
      rstSync_q <= {rstSync_q[0], 1'b1};
    end
  end
  assign rstn = rstSync_q[1];
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      state_q <= ST_VEC;
    end else begin
      case (state_q)
        ST_VEC: begin
          if (vecValid) begin
            state_q <= ST_RUN;
          end
        end
        ST_RUN: state_q <= ST_RUN;
        default: state_q <= ST_VEC;
      endcase
    end
  end
  assign vecReq = (state_q == ST_VEC);
  assign running = (state_q == ST_RUN);
  assign opGo = opValid && running && !opFromMem;
  assign memGo = memValid && running;
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      pc_q <= PC_RESET_VAL;
    end else if (state_q == ST_VEC && vecValid) begin
      pc_q <= vecPc;
    end else if (regWrite && regAddr == ADDR_PC) begin
      pc_q <= regWData;
    end
  end
  // no reset: code page keeps its previous value through reset in minimum mode
  always_ff @(posedge core_clk) begin
    if (state_q == ST_VEC && vecValid && maxMode) begin
      codePage_q <= vecCodePage;
    end else if (regWrite && regAddr == ADDR_CP) begin
      codePage_q <= regWData[7:0];
    end
  end
  // page and base registers come out of reset undetermined
  always_ff @(posedge core_clk) begin
    if (regWrite && regAddr == ADDR_DP) begin
      dataPage_q <= regWData[7:0];
    end
    if (regWrite && regAddr == ADDR_EP) begin
      extPage_q <= regWData[7:0];
    end
    if (regWrite && regAddr == ADDR_TP) begin
      stackPage_q <= regWData[7:0];
    end
    if (regWrite && regAddr == ADDR_BR) begin
      base_q <= regWData[7:0];
    end
  end
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      srTrace_q <= SR_TRACE_RESET;
      srMask_q <= SR_MASK_RESET;
    end else if (regWrite && regAddr == ADDR_SR) begin
      srTrace_q <= regWData[SR_TRACE_BIT];
      srMask_q <= regWData[SR_MASK_MSB:SR_MASK_LSB];
    end
  end
  // condition flags stay undetermined through reset
  always_ff @(posedge core_clk) begin
    if (regWrite && regAddr == ADDR_SR) begin
      srFlags_q <= regWData[3:0];
    end
  end
  assign srView = {srTrace_q, 4'h0, srMask_q, 4'h0, srFlags_q} & SR_WRITE_MASK;
  assign spNow = gr_q[SP_INDEX];
  always_comb begin
    effAddr = memAddr;
    spNext = spNow;
    if (memStack == STK_PREDEC) begin
      effAddr = spNow - STACK_STEP;
      spNext = spNow - STACK_STEP;
    end else if (memStack == STK_POSTINC) begin
      effAddr = spNow;
      spNext = spNow + STACK_STEP;
    end
  end
  assign spUpdate = memGo && memStack != STK_NONE && !mem.err;
  assign mem.req = memGo;
  assign mem.addr = effAddr;
  assign mem.word = memWord || memExc || memStack != STK_NONE;
  cpr_align_check u_align (
    .mem(mem)
  );
  // general registers: register port, then operations, then stack updates
  for (genvar i = 0; i < GR_COUNT; i++) begin : g_gr
    logic [15:0] grD;
    logic grEn;
    always_comb begin
      grD = gr_q[i];
      grEn = 1'b0;
      if (regWrite && regAddr == i[3:0]) begin
        grEn = 1'b1;
        grD = regWData;
      end else if (opGo && (opKind == OP_BYTE || opKind == OP_BCD) && opReg == i[2:0]) begin
        grEn = 1'b1;
        grD = {gr_q[i][15:8], opData[7:4], opData[3:0]};
      end else if (opGo && opKind == OP_WORD && opReg == i[2:0]) begin
        grEn = 1'b1;
        grD = opData[15:0];
      end else if (opGo && opKind == OP_LONG && opReg[2:1] == i[2:1]) begin
        grEn = 1'b1;
        grD = i[0] ? opData[15:0] : opData[31:16];
      end else if (opGo && opKind == OP_BSET && opReg == i[2:0]) begin
        grEn = 1'b1;
        grD[opBitNum] = 1'b1;
      end else if (opGo && opKind == OP_BCLR && opReg == i[2:0]) begin
        grEn = 1'b1;
        grD[opBitNum] = 1'b0;
      end else if (opGo && opKind == OP_BNOT && opReg == i[2:0]) begin
        grEn = 1'b1;
        grD[opBitNum] = ~gr_q[i][opBitNum];
      end else if (i == SP_INDEX && spUpdate) begin
        grEn = 1'b1;
        grD = spNext;
      end
    end
    // no reset on general registers
    always_ff @(posedge core_clk) begin
      if (grEn) begin
        gr_q[i] <= grD;
      end
    end
  end
  // memory bit operand: byte uses bits 7..0 only
  assign memBit = opMemWord ? opBitNum : {1'b0, opBitNum[2:0]};
  always_comb begin
    memOperand = opMemWord ? opData[15:0] : {8'h00, opData[7:0]};
    if (opKind == OP_BSET) begin
      memOperand[memBit] = 1'b1;
    end else if (opKind == OP_BCLR) begin
      memOperand[memBit] = 1'b0;
    end else if (opKind == OP_BNOT) begin
      memOperand[memBit] = ~memOperand[memBit];
    end
  end
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      opBitValue <= 1'b0;
      opResult <= 16'h0000;
    end else if (opValid && running && opFromMem) begin
      opBitValue <= opData[memBit];
      opResult <= memOperand;
    end else if (opGo) begin
      opBitValue <= gr_q[opReg][opBitNum];
    end
  end
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      busReq <= 1'b0;
      busAddr <= 16'h0000;
      busWrite <= 1'b0;
      busLaneEn <= LANE_NONE;
      busWData <= 16'h0000;
      addrError <= 1'b0;
    end else begin
      busReq <= memGo && !mem.err;
      addrError <= mem.err;
      busLaneEn <= mem.laneEn;
      busWrite <= memGo && memWrite && !mem.err;
      if (memGo) begin
        busAddr <= effAddr;
        busWData <= mem.word ? memData : {memData[7:0], memData[7:0]};
      end
    end
  end
  // read data for one cycle only
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      regRData <= 16'h0000;
    end else if (regRead) begin
      if (regAddr[3] == 1'b0) begin
        regRData <= gr_q[regAddr[2:0]];
      end else if (regAddr == ADDR_PC) begin
        regRData <= pc_q;
      end else if (regAddr == ADDR_SR) begin
        regRData <= srView;
      end else if (regAddr == ADDR_CP) begin
        regRData <= {8'h00, codePage_q};
      end else if (regAddr == ADDR_DP) begin
        regRData <= {8'h00, dataPage_q};
      end else if (regAddr == ADDR_EP) begin
        regRData <= {8'h00, extPage_q};
      end else if (regAddr == ADDR_TP) begin
        regRData <= {8'h00, stackPage_q};
      end else if (regAddr == ADDR_BR) begin
        regRData <= {8'h00, base_q};
      end else begin
        regRData <= 16'h0000;
      end
    end else begin
      regRData <= 16'h0000;
    end
  end
  cpr_insn_format u_fmt (
    .core_clk(core_clk),
    .rstn(rstn),
    .byteValid(insnValid),
    .byteIn(insnByte),
    .tailLen(insnTailLen),
    .fmtValid(fmtValid),
    .fmtKind(fmtKind),
    .eaField(fmtEaField),
    .opcode(fmtOpcode),
    .eaExt(fmtEaExt)
  );

  a_sr_reset_val: assert property (@(posedge core_clk) $rose(rstn) |->
    srMask_q == SR_MASK_RESET && srTrace_q == 1'b0) else $error("status not 070x after reset");
  a_vec_pc_load: assert property (@(posedge core_clk) disable iff (!rstn)
    (vecReq && vecValid) |=> pc_q == $past(vecPc) && running) else $error("pc not from vector");
  a_cp_max_load: assert property (@(posedge core_clk) disable iff (!rstn)
    (vecReq && vecValid && maxMode) |=> codePage_q == $past(vecCodePage))
    else $error("code page not from vector");
  a_byte_upper_keep: assert property (@(posedge core_clk) disable iff (!rstn)
    (opGo && opKind == OP_BYTE && opReg == 3'h1 && !regWrite) |=>
    gr_q[1][15:8] == $past(gr_q[1][15:8]) && gr_q[1][7:0] == $past(opData[7:0]))
    else $error("byte write disturbed upper byte");
  a_long_pair: assert property (@(posedge core_clk) disable iff (!rstn)
    (opGo && opKind == OP_LONG && opReg[2:1] == 2'h1 && !regWrite) |=>
    gr_q[2] == $past(opData[31:16]) && gr_q[3] == $past(opData[15:0]))
    else $error("longword pair misplaced");
  a_sr_reserved: assert property (@(posedge core_clk) disable iff (!rstn)
    (regRead && regAddr == ADDR_SR) |=> (regRData & ~SR_WRITE_MASK) == 16'h0000)
    else $error("reserved status bits nonzero");
  a_odd_word_err: assert property (@(posedge core_clk) disable iff (!rstn)
    (memGo && memWord && effAddr[0]) |=> addrError && !busReq && busLaneEn == LANE_NONE)
    else $error("odd word access not flagged");
  a_stack_word: assert property (@(posedge core_clk) disable iff (!rstn)
    (memGo && (memStack != STK_NONE || memExc)) |=> addrError || busLaneEn == LANE_BOTH)
    else $error("stack access not word size");
  a_sp_step: assert property (@(posedge core_clk) disable iff (!rstn)
    (memGo && memStack == STK_POSTINC && !spNow[0] && !regWrite && !opGo) |=>
    spNow == $past(spNow) + STACK_STEP) else $error("stack pointer step wrong");
  a_byte_lane: assert property (@(posedge core_clk) disable iff (!rstn)
    (memGo && !mem.word && !effAddr[0]) |=> busLaneEn == LANE_HIGH)
    else $error("even byte not on high lane");
endmodule // cpr_core_regs
`default_nettype wire

// ---- verification/cpr_mem_model.sv ----
// vector table and byte-lane memory model facing the register core
`default_nettype none
module cpr_mem_model #(
  parameter logic [15:0] PcVec = 16'h0246,
  parameter logic [7:0] CpVec = 8'h3c,
  parameter int VecDelay = 3
) (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic vecReq,
  output logic vecValid,
  output logic [15:0] vecPc,
  output logic [7:0] vecCodePage,
  input wire logic busReq,
  input wire logic [15:0] busAddr,
  input wire logic busWrite,
  input wire logic [1:0] busLaneEn,
  input wire logic [15:0] busWData
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem [0:255];
  int waitCnt;
  // vector lines carry junk outside the valid cycle
  assign vecPc = vecValid ? PcVec : ~PcVec;
  assign vecCodePage = vecValid ? CpVec : ~CpVec;
  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      waitCnt <= 0;
      vecValid <= 1'b0;
    end else begin
      vecValid <= 1'b0;
      waitCnt <= vecReq ? waitCnt + 1 : 0;
      if (vecReq && !vecValid && waitCnt >= VecDelay) vecValid <= 1'b1;
    end
  end
  // even address holds the high lane
  always @(posedge core_clk) begin
    if (busReq && busWrite && busLaneEn[1]) mem[{busAddr[7:1], 1'b0}] <= busWData[15:8];
    if (busReq && busWrite && busLaneEn[0]) mem[{busAddr[7:1], 1'b1}] <= busWData[7:0];
  end
endmodule // cpr_mem_model
`default_nettype wire

// ---- verification/cpr_core_regs_tb.sv ----
// self-checking bench for the cpu register core
`default_nettype none
module cpr_core_regs_tb import cpr_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [15:0] Pc = 16'h0246;
  localparam logic [7:0] Cp = 8'h3c;
  logic core_clk = 1'b0, resetn = 1'b0, maxMode = 1'b1;
  logic vecReq, vecValid, running, opBitValue, busReq, busWrite, addrError, fmtValid;
  logic [15:0] vecPc, regRData, opResult, busAddr, busWData, fmtEaExt;
  logic [7:0] vecCodePage, fmtEaField, fmtOpcode;
  logic [1:0] busLaneEn;
  cpr_fmt_t fmtKind;
  logic regWrite = 1'b0, regRead = 1'b0, opValid = 1'b0, opFromMem = 1'b0, opMemWord = 1'b0;
  logic memValid = 1'b0, memWord = 1'b0, memWrite = 1'b0, memExc = 1'b0, insnValid = 1'b0;
  logic [3:0] regAddr = 4'h0, opBitNum = 4'h0;
  logic [15:0] regWData = 16'h0000, memAddr = 16'h0000, memData = 16'h0000;
  logic [31:0] opData = 32'h0000_0000;
  logic [2:0] opReg = 3'h0;
  logic [7:0] insnByte = 8'h00;
  logic [1:0] insnTailLen = 2'h0;
  cpr_op_t opKind = OP_NONE;
  cpr_stack_t memStack = STK_NONE;
  int miscompares = 0, nCompared = 0;

  cpr_core_regs i_cpr_core_regs (.core_clk, .resetn, .maxMode, .vecReq, .vecValid, .vecPc,
    .vecCodePage, .running, .regAddr, .regWData, .regWrite, .regRead, .regRData, .opValid,
    .opKind, .opReg, .opData, .opBitNum, .opFromMem, .opMemWord, .opBitValue, .opResult,
    .memValid, .memAddr, .memWord, .memWrite, .memData, .memStack, .memExc, .busReq,
    .busAddr, .busWrite, .busLaneEn, .busWData, .addrError, .insnValid, .insnByte,
    .insnTailLen, .fmtValid, .fmtKind, .fmtEaField, .fmtOpcode, .fmtEaExt);
  cpr_mem_model #(.PcVec(Pc), .CpVec(Cp)) i_cpr_mem_model (.core_clk, .resetn, .vecReq,
    .vecValid, .vecPc, .vecCodePage, .busReq, .busAddr, .busWrite, .busLaneEn, .busWData);

  always #4 core_clk = ~core_clk;

  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    nCompared++;
    if (got !== exp) begin
      miscompares++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge core_clk);
    regAddr <= a;
    regWData <= d;
    regWrite <= 1'b1;
    @(posedge core_clk);
    regWrite <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [15:0] e, input logic [15:0] m = 16'hffff);
    @(posedge core_clk);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge core_clk);
    regRead <= 1'b0;
    #1 chk("regRData", e, regRData & m);
  endtask
  task automatic op(input cpr_op_t k, input logic [2:0] r, input logic [31:0] d,
      input logic [3:0] b, input logic fm, input logic mw);
    @(posedge core_clk);
    opValid <= 1'b1;
    opKind <= k;
    opReg <= r;
    opData <= d;
    opBitNum <= b;
    opFromMem <= fm;
    opMemWord <= mw;
    @(posedge core_clk);
    opValid <= 1'b0;
    #1;
  endtask
  task automatic mem(input logic [15:0] a, input logic w, input logic wn, input logic [15:0] d,
      input cpr_stack_t s, input logic x);
    @(posedge core_clk);
    memValid <= 1'b1;
    memAddr <= a;
    memWord <= w;
    memWrite <= wn;
    memData <= d;
    memStack <= s;
    memExc <= x;
    @(posedge core_clk);
    memValid <= 1'b0;
    #1;
  endtask
  task automatic bus(input logic rq, input logic er, input logic [1:0] ln, input logic [15:0] a);
    chk("busReq", {15'h0, rq}, {15'h0, busReq});
    chk("addrError", {15'h0, er}, {15'h0, addrError});
    chk("busLaneEn", {14'h0, ln}, {14'h0, busLaneEn});
    if (rq) chk("busAddr", a, busAddr);
  endtask
  task automatic ins(input logic [7:0] b, input logic [1:0] t);
    @(posedge core_clk);
    insnValid <= 1'b1;
    insnByte <= b;
    insnTailLen <= t;
    @(posedge core_clk);
    insnValid <= 1'b0;
    #1;
  endtask
  task automatic fmt(input logic [1:0] k, input logic [7:0] o);
    chk("fmtValid", 16'h1, {15'h0, fmtValid});
    chk("fmtKind", {14'h0, k}, {14'h0, fmtKind});
    chk("fmtOpcode", {8'h0, o}, {8'h0, fmtOpcode});
  endtask
  task automatic doReset(input logic mx);
    @(posedge core_clk);
    resetn <= 1'b0;
    maxMode <= mx;
    repeat (4) @(posedge core_clk);
    resetn <= 1'b1;
    #1 chk("vecReq", 16'h1, {15'h0, vecReq});
    for (int i = 0; i < 20 && running !== 1'b1; i++) @(posedge core_clk);
    chk("running", 16'h1, {15'h0, running});
    rd(ADDR_PC, Pc);
    rd(ADDR_SR, 16'h0700, 16'hfff0);
  endtask
  task automatic conclude();
    $display("compared %0d mismatched %0d", nCompared, miscompares);
    if (miscompares == 0 && nCompared > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  initial begin
    #20000;
    miscompares++;
    conclude();
  end

  initial begin
    doReset(1'b1);
    rd(ADDR_CP, {8'h0, Cp}, 16'h00ff);
    wr(ADDR_SR, 16'hffff);
    rd(ADDR_SR, 16'h870f);
    wr(ADDR_TP, 16'h0011);
    wr({1'b0, SP_INDEX}, 16'h0100);
    wr(ADDR_BR, 16'h00ab);
    rd(ADDR_BR, 16'h00ab, 16'h00ff);
    wr(4'hf, 16'h1234);
    rd(4'hf, 16'h0000);
    $display("test reset and status done");
    wr(4'h1, 16'habcd);
    op(OP_BYTE, 3'h1, 32'h12, 4'h0, 1'b0, 1'b0);
    rd(4'h1, 16'hab12);
    op(OP_BCD, 3'h1, 32'h59, 4'h0, 1'b0, 1'b0);
    rd(4'h1, 16'hab59);
    op(OP_WORD, 3'h1, 32'h1234_5678, 4'h0, 1'b0, 1'b0);
    rd(4'h1, 16'h5678);
    op(OP_LONG, 3'h3, 32'h1111_2222, 4'h0, 1'b0, 1'b0);
    rd(4'h2, 16'h1111);
    rd(4'h3, 16'h2222);
    wr(4'h0, 16'h0000);
    op(OP_BSET, 3'h0, 32'h0, 4'hf, 1'b0, 1'b0);
    chk("opBitValue", 16'h0, {15'h0, opBitValue});
    op(OP_BNOT, 3'h0, 32'h0, 4'h0, 1'b0, 1'b0);
    rd(4'h0, 16'h8001);
    op(OP_BCLR, 3'h0, 32'h0, 4'hf, 1'b0, 1'b0);
    chk("opBitValue", 16'h1, {15'h0, opBitValue});
    op(OP_BSET, 3'h0, 32'h0100, 4'h9, 1'b1, 1'b1);
    chk("opResult", 16'h0300, opResult);
    op(OP_BNOT, 3'h0, 32'h00f0, 4'hc, 1'b1, 1'b0);
    chk("opResult", 16'h00e0, {8'h0, opResult[7:0]});
    rd(4'h0, 16'h0001);
    $display("test operand formats done");
    mem(16'h0004, 1'b0, 1'b1, 16'h00c5, STK_NONE, 1'b0);
    bus(1'b1, 1'b0, 2'b10, 16'h0004);
    chk("busWData", 16'hc5c5, busWData);
    mem(16'h0005, 1'b0, 1'b1, 16'h0077, STK_NONE, 1'b0);
    bus(1'b1, 1'b0, 2'b01, 16'h0005);
    mem(16'h0006, 1'b1, 1'b1, 16'h1234, STK_NONE, 1'b0);
    bus(1'b1, 1'b0, 2'b11, 16'h0006);
    mem(16'h0005, 1'b1, 1'b1, 16'hdead, STK_NONE, 1'b0);
    bus(1'b0, 1'b1, 2'b00, 16'h0);
    mem(16'h0009, 1'b0, 1'b0, 16'h0, STK_NONE, 1'b1);
    bus(1'b0, 1'b1, 2'b00, 16'h0);
    mem(16'h0008, 1'b0, 1'b0, 16'h0, STK_NONE, 1'b1);
    bus(1'b1, 1'b0, 2'b11, 16'h0008);
    chk("mem67", 16'h1234, {i_cpr_mem_model.mem[6], i_cpr_mem_model.mem[7]});
    chk("mem45", 16'hc577, {i_cpr_mem_model.mem[4], i_cpr_mem_model.mem[5]});
    mem(16'h0, 1'b0, 1'b1, 16'h55aa, STK_PREDEC, 1'b0);
    bus(1'b1, 1'b0, 2'b11, 16'h00fe);
    rd({1'b0, SP_INDEX}, 16'h00fe);
    mem(16'h0, 1'b0, 1'b0, 16'h0, STK_POSTINC, 1'b0);
    bus(1'b1, 1'b0, 2'b11, 16'h00fe);
    rd({1'b0, SP_INDEX}, 16'h0100);
    wr({1'b0, SP_INDEX}, 16'h0101);
    mem(16'h0, 1'b0, 1'b1, 16'h0, STK_PREDEC, 1'b0);
    bus(1'b0, 1'b1, 2'b00, 16'h0);
    rd({1'b0, SP_INDEX}, 16'h0101);
    $display("test memory and stack done");
    ins(8'he0, 2'd0);
    chk("fmtValid", 16'h0, {15'h0, fmtValid});
    ins(8'h12, 2'd0);
    ins(8'h55, 2'd0);
    fmt(2'd0, 8'h55);
    chk("fmtEaExt", 16'h0012, fmtEaExt);
    chk("fmtEaField", 16'h00e0, {8'h0, fmtEaField});
    ins(8'ha3, 2'd0);
    ins(PREFIX_CODE, 2'd0);
    ins(8'ha3, 2'd0);
    fmt(2'd1, 8'ha3);
    ins(8'h20, 2'd2);
    ins(8'h33, 2'd0);
    ins(8'h44, 2'd0);
    fmt(2'd2, 8'h20);
    ins(8'h21, 2'd0);
    fmt(2'd2, 8'h21);
    $display("test decoder done");
    wr(ADDR_SR, 16'h8000);
    wr(ADDR_CP, 16'h0055);
    doReset(1'b0);
    rd(ADDR_CP, 16'h0055, 16'h00ff);
    $display("test minimum mode reset done");
    conclude();
  end
endmodule // cpr_core_regs_tb
`default_nettype wire
